// file: include/rfs_pkg.sv
// shared constants, register map and carrier types of the regulator supervisor
package rfs_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ         = 200_000_000;
    localparam int unsigned FSW_DEFAULT_HZ = 500_000;
    localparam int unsigned FSW_MIN_HZ     = 200_000;
    localparam int unsigned FSW_MAX_HZ     = 2_200_000;
    localparam int unsigned FOLD_MIN_HZ    = 40_000;
    localparam int unsigned SYNC_OFS_NS    = 220;
    localparam int unsigned CLK_NS         = 5;

    localparam logic [15:0] PER_DEFAULT = 16'(CLK_HZ / FSW_DEFAULT_HZ);
    localparam logic [15:0] PER_MAX     = 16'(CLK_HZ / FSW_MIN_HZ);
    localparam logic [15:0] PER_MIN     = 16'((CLK_HZ + FSW_MAX_HZ - 1) / FSW_MAX_HZ);
    localparam int unsigned FOLD_CYC    = CLK_HZ / FOLD_MIN_HZ;
    localparam logic [15:0] SYNC_OFS_CYC = 16'((SYNC_OFS_NS + CLK_NS - 1) / CLK_NS);

    // ------------------------------------------------------------
    // counted delays in switching periods, and the phase accumulator step
    // ------------------------------------------------------------
    localparam logic [7:0]  PG_DELAY     = 8'h80;
    localparam logic [1:0]  OC2_DELAY    = 2'h2;
    localparam logic [2:0]  HICCUP_MULT  = 3'h5;
    localparam logic [8:0]  PH_FULL_STEP = 9'h100;
    localparam int unsigned PH_FRAC      = 8;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_PERIOD = 8'h08;
    localparam logic [7:0] ADDR_CAP    = 8'h0c;

    localparam int unsigned CTRL_SKIP  = 0;
    localparam int unsigned CTRL_SLAVE = 1;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_OFF,
        ST_SOFT,
        ST_RUN,
        ST_HICCUP
    } rfs_state_t;

    // comparator levels from the analog front end, all asynchronous
    typedef struct packed {
        logic boost_above_mode;
        logic boost_above_dis;
        logic aux_above_dis;
        logic fb_over_110;
        logic fb_over_120;
        logic fb_under_90;
        logic fb_below_ref;
        logic peak_limit_primary;
        logic peak_limit_hiccup;
        logic temp_trip;
        logic temp_release;
        logic enable;
        logic bias_por_ok;
        logic bias_above_1v;
        logic pwm_end;
        logic skip_demand;
    } rfs_sense_t;

    typedef struct packed {
        logic high_side_gate;
        logic low_side_gate;
    } rfs_gate_t;

endpackage

// file: src/rfs_supervisor.sv
// regulator mode latch, oscillator with clock lock, power-good and fault control
//
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
module rfs_supervisor #(
    parameter int unsigned SS_PERIODS = 1024,
    parameter int unsigned FOLD_MAX   = rfs_pkg::FOLD_CYC
) (
    // clock and reset
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    // axi4-lite write address and data
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // analog front end
    input  wire rfs_pkg::rfs_sense_t  sense_in,
    input  wire logic [7:0]           fold_level,
    output logic [7:0]                current_cap_code,
    // power stage
    output rfs_pkg::rfs_gate_t        gate_out,
    // sync pin
    input  wire logic                 sync_pin_i,
    output logic                      sync_pin_o,
    output logic                      sync_pin_oe,
    // power-good open drain
    output logic                      power_ok_flag_o,
    output logic                      power_ok_flag_oe
);
    import rfs_pkg::*;

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    rfs_sense_t sense_meta_reg;
    rfs_sense_t sn;
    logic       sync_meta_reg;
    logic       sync_s_reg;
    logic       sync_d_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sense_meta_reg <= '0;
            sn             <= '0;
            sync_meta_reg  <= 1'b0;
            sync_s_reg     <= 1'b0;
            sync_d_reg     <= 1'b0;
        end else begin
            sense_meta_reg <= sense_in;
            sn             <= sense_meta_reg;
            sync_meta_reg  <= sync_pin_i;
            sync_s_reg     <= sync_meta_reg;
            sync_d_reg     <= sync_s_reg;
        end
    end

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [1:0]  ctrl_reg;
    logic [15:0] period_reg;
    logic [7:0]  cap_reg;
    logic        wr_go;
    logic        wr_hit;
    logic [31:0] status_word;

    rfs_state_t  state_reg;
    logic        boost_mode_reg;
    logic        pg_reg;
    logic        ovp_hold_reg;
    logic        ot_hold_reg;
    logic        limiting_reg;
    logic        locked_reg;

    assign wr_go         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_hit        = (s_axi_awaddr == ADDR_CTRL) || (s_axi_awaddr == ADDR_PERIOD)
                           || (s_axi_awaddr == ADDR_CAP);
    assign status_word   = {24'h0, locked_reg, limiting_reg, ot_hold_reg, ovp_hold_reg,
                            pg_reg, boost_mode_reg, state_reg};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg   <= 2'h0;
            period_reg <= 16'h0;
            cap_reg    <= 8'h0;
        end else if (wr_go && s_axi_wstrb[0]) begin
            if (s_axi_awaddr == ADDR_CTRL) begin
                ctrl_reg <= s_axi_wdata[1:0];
            end
            if (s_axi_awaddr == ADDR_PERIOD) begin
                period_reg[7:0] <= s_axi_wdata[7:0];
            end
            if (s_axi_awaddr == ADDR_CAP) begin
                cap_reg <= s_axi_wdata[7:0];
            end
        end
        if (aresetn && wr_go && s_axi_wstrb[1] && s_axi_awaddr == ADDR_PERIOD) begin
            period_reg[15:8] <= s_axi_wdata[15:8];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            case (s_axi_araddr)
                ADDR_CTRL:   s_axi_rdata <= {30'h0, ctrl_reg};
                ADDR_STATUS: s_axi_rdata <= status_word;
                ADDR_PERIOD: s_axi_rdata <= {16'h0, period_reg};
                ADDR_CAP:    s_axi_rdata <= {24'h0, cap_reg};
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // analog limit setting; zero keeps the default threshold
    assign current_cap_code = cap_reg;

    // ------------------------------------------------------------
    // oscillator, foldback and clock lock
    // ------------------------------------------------------------
    logic [15:0] per_eff;
    logic [23:0] ph_reg;
    logic [23:0] ph_sum;
    logic [8:0]  ph_step;
    logic [15:0] cyc_reg;
    logic [15:0] lock_dly_reg;
    logic        lock_arm_reg;
    logic [15:0] lock_dly2_reg;
    logic        lock_arm2_reg;
    logic [15:0] lock_load;
    logic        fire_one;
    logic        fire_two;
    logic        use_two;
    logic        per_end;
    logic        lock_fire;
    logic        tick;
    logic        skip_act;
    logic        slave_act;
    logic        sync_rise;

    always_comb begin
        if (period_reg == 16'h0) begin
            per_eff = PER_DEFAULT;
        end else if (period_reg < PER_MIN) begin
            per_eff = PER_MIN;
        end else if (period_reg > PER_MAX) begin
            per_eff = PER_MAX;
        end else begin
            per_eff = period_reg;
        end
    end

    assign skip_act  = ctrl_reg[CTRL_SKIP] && !boost_mode_reg;
    assign slave_act = ctrl_reg[CTRL_SLAVE] && !skip_act;
    assign sync_rise = sync_s_reg && !sync_d_reg;
    // foldback slows the phase accumulator by the sensed output level
    assign ph_step   = limiting_reg ? ((fold_level == 8'h0) ? 9'h1 : {1'b0, fold_level})
                                    : PH_FULL_STEP;
    assign ph_sum    = ph_reg + {15'h0, ph_step};
    assign per_end   = (ph_sum >= {per_eff, 8'h0})
                       || (cyc_reg >= 16'(FOLD_MAX - 1));
    assign fire_one  = lock_arm_reg && (lock_dly_reg == 16'h0);
    assign fire_two  = lock_arm2_reg && (lock_dly2_reg == 16'h0);
    assign lock_fire = fire_one || fire_two;
    // the delay can outlast one external period, so the next edge then queues in slot two
    assign use_two   = lock_arm_reg && !fire_one;
    assign lock_load = {1'b0, per_eff[15:1]} + SYNC_OFS_CYC - 16'h1;
    assign tick      = per_end || lock_fire;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ph_reg  <= 24'h0;
            cyc_reg <= 16'h0;
        end else if (tick) begin
            ph_reg  <= 24'h0;
            cyc_reg <= 16'h0;
        end else begin
            ph_reg  <= ph_sum;
            cyc_reg <= cyc_reg + 16'h1;
        end
    end

    // slave: restart half a period plus a fixed offset after each sync rise
    always_ff @(posedge aclk) begin
        if (!aresetn || !slave_act) begin
            lock_arm_reg <= 1'b0;
            lock_dly_reg <= 16'h0;
        end else if (sync_rise && !use_two) begin
            lock_arm_reg <= 1'b1;
            lock_dly_reg <= lock_load;
        end else if (fire_one) begin
            lock_arm_reg <= 1'b0;
        end else if (lock_dly_reg != 16'h0) begin
            lock_dly_reg <= lock_dly_reg - 16'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || !slave_act) begin
            lock_arm2_reg <= 1'b0;
            lock_dly2_reg <= 16'h0;
        end else if (sync_rise && use_two) begin
            lock_arm2_reg <= 1'b1;
            lock_dly2_reg <= lock_load;
        end else if (fire_two) begin
            lock_arm2_reg <= 1'b0;
        end else if (lock_dly2_reg != 16'h0) begin
            lock_dly2_reg <= lock_dly2_reg - 16'h1;
        end
    end

    // lock is lost when the free-running count ends a period with no edge pending
    always_ff @(posedge aclk) begin
        if (!aresetn || !slave_act) begin
            locked_reg <= 1'b0;
        end else if (sync_rise) begin
            locked_reg <= 1'b1;
        end else if (per_end && !lock_arm_reg && !lock_arm2_reg) begin
            locked_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_pin_o  <= 1'b0;
            sync_pin_oe <= 1'b0;
        end else begin
            sync_pin_o  <= ph_reg < {1'b0, per_eff, 7'h0};
            sync_pin_oe <= !ctrl_reg[CTRL_SLAVE] && !skip_act;
        end
    end

    // ------------------------------------------------------------
    // start-up sequence and hiccup
    // ------------------------------------------------------------
    logic [19:0] seq_cnt_reg;
    logic [1:0]  oc2_cnt_reg;
    logic        oc2_pend_reg;
    logic        on_ok;

    assign on_ok = sn.enable && sn.bias_por_ok;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg      <= ST_OFF;
            boost_mode_reg <= 1'b0;
            seq_cnt_reg    <= 20'h0;
            oc2_pend_reg   <= 1'b0;
            oc2_cnt_reg    <= 2'h0;
        end else if (!on_ok) begin
            state_reg    <= ST_OFF;
            oc2_pend_reg <= 1'b0;
        end else begin
            if (sn.peak_limit_hiccup && !oc2_pend_reg
                && (state_reg == ST_SOFT || state_reg == ST_RUN)) begin
                oc2_pend_reg <= 1'b1;
                oc2_cnt_reg  <= 2'h0;
            end else if (oc2_pend_reg && tick) begin
                oc2_cnt_reg <= oc2_cnt_reg + 2'h1;
            end
            case (state_reg)
                ST_OFF: begin
                    boost_mode_reg <= sn.boost_above_mode;
                    seq_cnt_reg    <= 20'h0;
                    state_reg      <= ST_SOFT;
                end
                ST_SOFT, ST_RUN: begin
                    if (oc2_pend_reg && tick && oc2_cnt_reg == OC2_DELAY - 2'h1) begin
                        state_reg    <= ST_HICCUP;
                        seq_cnt_reg  <= 20'h0;
                        oc2_pend_reg <= 1'b0;
                    end else if (state_reg == ST_SOFT && tick) begin
                        if (seq_cnt_reg == 20'(SS_PERIODS - 1)) begin
                            state_reg <= ST_RUN;
                        end
                        seq_cnt_reg <= seq_cnt_reg + 20'h1;
                    end
                end
                ST_HICCUP: begin
                    if (tick) begin
                        if (seq_cnt_reg == 20'(HICCUP_MULT * SS_PERIODS - 1)) begin
                            state_reg   <= ST_SOFT;
                            seq_cnt_reg <= 20'h0;
                        end else begin
                            seq_cnt_reg <= seq_cnt_reg + 20'h1;
                        end
                    end
                end
                default: state_reg <= ST_OFF;
            endcase
        end
    end

    // ------------------------------------------------------------
    // overvoltage and thermal holds
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ovp_hold_reg <= 1'b0;
            ot_hold_reg  <= 1'b0;
        end else begin
            if (sn.fb_over_120 || (sn.fb_over_110 && state_reg == ST_RUN)) begin
                ovp_hold_reg <= 1'b1;
            end else if (sn.fb_below_ref) begin
                ovp_hold_reg <= 1'b0;
            end
            if (sn.temp_trip) begin
                ot_hold_reg <= 1'b1;
            end else if (sn.temp_release) begin
                ot_hold_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // gate drive
    // ------------------------------------------------------------
    logic gate_ok;
    logic hs_reg;
    logic hs_next;
    logic ls_next;
    logic boost_run;
    logic lim_seen_reg;

    assign gate_ok   = (state_reg == ST_SOFT || state_reg == ST_RUN) && !ovp_hold_reg
                       && !ot_hold_reg;
    assign boost_run = boost_mode_reg && !sn.boost_above_dis && !sn.aux_above_dis;

    always_comb begin
        hs_next = hs_reg;
        if (!gate_ok) begin
            hs_next = 1'b0;
        end else if (tick) begin
            hs_next = !skip_act || sn.skip_demand;
        end else if (sn.pwm_end || sn.peak_limit_primary) begin
            hs_next = 1'b0;
        end
        if (boost_mode_reg) begin
            ls_next = hs_next && boost_run;
        end else begin
            ls_next = !hs_next && gate_ok;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hs_reg   <= 1'b0;
            gate_out <= '0;
        end else begin
            hs_reg                  <= hs_next;
            gate_out.high_side_gate <= hs_next;
            gate_out.low_side_gate  <= ls_next;
        end
    end

    // foldback stays on while any period of the last one hit the limit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lim_seen_reg <= 1'b0;
            limiting_reg <= 1'b0;
        end else if (tick) begin
            limiting_reg <= lim_seen_reg || sn.peak_limit_primary;
            lim_seen_reg <= 1'b0;
        end else if (sn.peak_limit_primary && hs_reg) begin
            lim_seen_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // power-good
    // ------------------------------------------------------------
    logic [7:0] pg_cnt_reg;
    logic       win_ok;

    assign win_ok = !sn.fb_over_110 && !sn.fb_under_90;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pg_reg     <= 1'b0;
            pg_cnt_reg <= 8'h0;
        end else if (!on_ok || state_reg != ST_RUN || !win_ok) begin
            pg_reg     <= 1'b0;
            pg_cnt_reg <= 8'h0;
        end else if (!pg_reg && tick) begin
            if (pg_cnt_reg == PG_DELAY - 8'h1) begin
                pg_reg <= 1'b1;
            end
            pg_cnt_reg <= pg_cnt_reg + 8'h1;
        end
    end

    // open drain pulls low only while bias is up and the flag is not good
    assign power_ok_flag_o  = 1'b0;
    assign power_ok_flag_oe = sn.bias_above_1v && !(pg_reg && on_ok);

endmodule

// file: sim/rfs_stage_model.sv
// power stage and peer clock source facing the supervisor
`timescale 1ns/10ps
module rfs_stage_model #(
    parameter int ON_CYC  = 30,
    parameter int HALF_NS = 32
) (
    // clock and power stage
    input  wire logic aclk,
    input  wire logic high_side_gate,
    output logic      pwm_end,
    // peer clock on the sync line
    input  wire logic ext_run,
    output logic      ext_clk
);
    logic [7:0] on_cnt = 8'h00;
    initial begin
        ext_clk = 1'b0;
        #3;
        // peer clock stands low outside its bursts
        forever #HALF_NS ext_clk = ext_run & ~ext_clk;
    end
    // current ramp meets the control level a fixed time into each pulse
    always @(posedge aclk) begin
        on_cnt <= high_side_gate ? on_cnt + 8'h01 : 8'h00;
        pwm_end <= high_side_gate && on_cnt >= 8'(ON_CYC);
    end
endmodule

// file: sim/rfs_supervisor_checker.sv
// concurrent checks on the supervisor pins
`timescale 1ns/10ps
module rfs_supervisor_checker (
    // clock and reset
    input wire logic                aclk,
    input wire logic                aresetn,
    // register bus handshakes
    input wire logic                s_axi_arvalid,
    input wire logic                s_axi_arready,
    input wire logic                s_axi_rvalid,
    input wire logic                s_axi_awready,
    input wire logic                s_axi_bvalid,
    // analog and power pins
    input wire rfs_pkg::rfs_sense_t sense_in,
    input wire rfs_pkg::rfs_gate_t  gate_out,
    input wire logic                power_ok_flag_o,
    input wire logic                power_ok_flag_oe
);
    import rfs_pkg::*;
    logic [15:0] ok_cnt;
    wire logic   bad  = sense_in.fb_under_90 || sense_in.fb_over_110;
    wire logic   bias = sense_in.bias_above_1v;
    // cycles since feedback last left the window
    always_ff @(posedge aclk) begin
        if (!aresetn || bad) begin
            ok_cnt <= 16'h0000;
        end else if (ok_cnt != 16'hffff) begin
            ok_cnt <= ok_cnt + 16'h0001;
        end
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    pg_odrain_a: assert property (!power_ok_flag_o) else $error("pg driven high");
    pg_bias_a: assert property ((!bias)[*3] |-> !power_ok_flag_oe)
        else $error("pg pulled without bias");
    pg_off_a: assert property ((!sense_in.enable && bias)[*4] |-> power_ok_flag_oe)
        else $error("pg not low when disabled");
    pg_fault_a: assert property ((bad && bias)[*4] |-> power_ok_flag_oe)
        else $error("pg not low on window fault");
    pg_hold_a: assert property (bias[*4] ##0 $fell(power_ok_flag_oe) |-> ok_cnt >= 16'h2d80)
        else $error("pg released early");
    ovp_gates_a: assert property (sense_in.fb_over_120[*5] |-> gate_out == '0)
        else $error("gates on during overvoltage");
    ot_gates_a: assert property (sense_in.temp_trip[*5] |-> gate_out == '0)
        else $error("gates on during overtemperature");
    peak_end_a: assert property (sense_in.peak_limit_primary[*4] |-> ##[0:2]
        !gate_out.high_side_gate) else $error("pulse not ended by limit");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    wr_answer_a: assert property (s_axi_awready |=> s_axi_bvalid) else $error("write not answered");
    cover property ($fell(power_ok_flag_oe));
    cover property (sense_in.temp_trip[*5]);
    cover property (s_axi_awready ##1 s_axi_bvalid);
endmodule
bind rfs_supervisor rfs_supervisor_checker u_chk (.*);

// file: sim/rfs_supervisor_tb.sv
// self-checking bench for the regulator supervisor
`timescale 1ns/10ps
module rfs_supervisor_tb;
    import rfs_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, ext_run = 1'b0, pwm_end, ext_clk;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, fold_level = 8'h00, cap;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, st = 2'h0;
    logic [7:0] current_cap_code;
    logic bst = 1'b0, pg = 1'b0, ov = 1'b0, ot = 1'b0;
    logic sync_pin_o, sync_pin_oe, power_ok_flag_o, power_ok_flag_oe;
    rfs_sense_t sn = '0, sense_in;
    rfs_gate_t gate_out;
    int num_errors = 0, check_count = 0;
    wire logic sync_pin_i = sync_pin_oe ? sync_pin_o : ext_clk;
    wire logic pg_line = power_ok_flag_oe ? power_ok_flag_o : 1'b1;
    wire logic [31:0] exp_st = {26'h0, ot, ov, pg, bst, st};
    always #2.5 aclk = ~aclk;
    always_comb begin
        sense_in = sn;
        sense_in.pwm_end = pwm_end;
    end
    rfs_supervisor #(.SS_PERIODS(4), .FOLD_MAX(2000)) dut (.*);
    // peer clock ten percent above the 500 ns free-running rate
    rfs_stage_model #(.HALF_NS(227)) model (.aclk(aclk),
        .high_side_gate(gate_out.high_side_gate), .pwm_end(pwm_end), .ext_run(ext_run),
        .ext_clk(ext_clk));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do @(posedge aclk); while (!s_axi_awready);
        {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
        do @(posedge aclk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        {v, r} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    // reads status until it meets the model, then compares
    task automatic poll(input logic [31:0] m, input int n);
        logic [31:0] v;
        logic [1:0] r;
        do begin
            rd(ADDR_STATUS, v, r);
            n--;
        end while ((v & m) !== (exp_st & m) && n > 0);
        chk(v & m, exp_st & m);
    endtask
    task automatic close_out();
        if (num_errors == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        logic [31:0] v;
        logic [1:0] r;
        int hi = 0;
        void'($urandom(52017));
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 5; i++) begin
            rd(8'(4 * i), v, r);
            chk(v, 32'h0);
            chk({30'h0, r}, {30'h0, (i == 4) ? RESP_SLVERR : RESP_OKAY});
        end
        wr(ADDR_STATUS, 32'h0, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        cap = 8'($urandom);
        fold_level <= 8'($urandom);
        wr(ADDR_CAP, {24'h0, cap}, r);
        wr(ADDR_PERIOD, 32'h64, r);
        wr(ADDR_CTRL, 32'h1, r);
        rd(ADDR_PERIOD, v, r);
        chk(v, 32'h64);
        chk({24'h0, current_cap_code}, {24'h0, cap});
        // mode sense high, enabled, biased, pulse demand on
        sn <= rfs_sense_t'(16'h801d);
        {bst, st} = 3'h5;
        poll(32'h3f, 50);
        st = 2'h2;
        poll(32'h3f, 300);
        chk(32'(sync_pin_oe), 32'h1);
        repeat (300) begin
            @(posedge aclk);
            chk(32'(gate_out.low_side_gate), 32'(gate_out.high_side_gate));
            hi += sync_pin_o;
        end
        chk(hi, 32'h96);
        pg = 1'b1;
        poll(32'h3f, 5000);
        sn.fb_under_90 <= 1'b1;
        pg = 1'b0;
        repeat (5) @(posedge aclk);
        chk(32'(pg_line), 32'h0);
        sn.fb_under_90 <= 1'b0;
        poll(32'h3f, 20);
        pg = 1'b1;
        poll(32'h3f, 5000);
        sn.enable <= 1'b0;
        {pg, st} = 3'h0;
        repeat (4) @(posedge aclk);
        chk(32'(pg_line), 32'h0);
        poll(32'h3b, 20);
        sn <= rfs_sense_t'(16'h001d);
        {bst, st} = 3'h1;
        poll(32'h3f, 50);
        chk(32'(sync_pin_oe), 32'h0);
        sn.fb_over_120 <= 1'b1;
        ov = 1'b1;
        poll(32'h10, 20);
        chk({30'h0, gate_out}, 32'h0);
        sn.fb_over_120 <= 1'b0;
        @(posedge aclk);
        sn.fb_below_ref <= 1'b1;
        ov = 1'b0;
        poll(32'h10, 20);
        sn.fb_below_ref <= 1'b0;
        st = 2'h2;
        poll(32'h3f, 300);
        sn.peak_limit_primary <= 1'b1;
        repeat (8) @(posedge aclk);
        sn.peak_limit_primary <= 1'b0;
        @(posedge aclk);
        sn.fb_over_110 <= 1'b1;
        ov = 1'b1;
        poll(32'h3f, 20);
        sn.fb_over_110 <= 1'b0;
        @(posedge aclk);
        sn.fb_below_ref <= 1'b1;
        ov = 1'b0;
        poll(32'h3f, 20);
        sn.fb_below_ref <= 1'b0;
        @(posedge aclk);
        sn.temp_trip <= 1'b1;
        ot = 1'b1;
        poll(32'h3f, 20);
        chk({30'h0, gate_out}, 32'h0);
        sn.temp_trip <= 1'b0;
        poll(32'h3f, 5);
        sn.temp_release <= 1'b1;
        ot = 1'b0;
        poll(32'h3f, 20);
        sn.peak_limit_hiccup <= 1'b1;
        st = 2'h3;
        poll(32'h3f, 1500);
        sn.peak_limit_hiccup <= 1'b0;
        repeat (1500) @(posedge aclk);
        poll(32'h3f, 1);
        st = 2'h1;
        poll(32'h3f, 1000);
        wr(ADDR_CTRL, 32'h2, r);
        ext_run <= 1'b1;
        repeat (100) @(posedge aclk);
        chk(32'(sync_pin_oe), 32'h0);
        rd(ADDR_STATUS, v, r);
        chk(v & 32'h80, 32'h80);
        ext_run <= 1'b0;
        close_out();
    end
    // the sequence needs about 30k cycles; this allows 80k, over twice that
    initial begin
        #400000;
        num_errors++;
        close_out();
    end
endmodule
